/* design/qdac_i2c_update.sv */
// Two-wire slave receiver that updates four 12-bit channel register pairs
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Start, matching address, control byte, upper then lower data byte form first update.
// - Each byte of a matched frame is acknowledged by holding data low over the next clock pulse, before a bad control byte or a lower byte met by a full queue.
// - Register update happens when the clock after the lower byte acknowledge falls.
// - Control byte is kept; every later data pair updates using it until replaced.
// - Later updates need only 18 clock cycles: two bytes and two acknowledges.
// - Stop releases the data line and waits for a new start.
// - First byte after start is the address; low bit is the direction.
// - Local address matches only when the five top bits equal 10011.
// - Next two address bits equal select pins captured once after power-up.
// - Broadcast address byte 1001 0000 is acknowledged regardless of select pins.
// - Broadcast is honoured for writes only; broadcast reads are ignored.
// - Control byte: top two bits zero, mode, ignored bit, channel, power-down flag.
// - Mode 00 writes only the selected temporary register.
// - Mode 01 writes temporary and output registers of the selected channel.
// - Mode 10 writes selected pair; other outputs take their temporaries together.
// - Mode 11 ignores channel select and updates all four channels together.
// - High-speed master code is never acknowledged; speed follows the bus clock.
// - Only seven-bit addressing; ten-bit and general call are not acknowledged.
// - With power-down flag set, upper byte top bits are power-down information.
module qdac_i2c_update (
  // Clock and reset
  input  wire logic                I_CLK,
  input  wire logic                I_NRST,
  // Two-wire bus
  input  wire logic                I_SCL,
  input  wire logic                I_SDA,
  output logic                     O_SDA_O,
  output logic                     O_SDA_OE,
  // Device select pins
  input  wire logic                I_DEV_SELECT_PIN_HI,
  input  wire logic                I_DEV_SELECT_PIN_LO,
  // Apply stage back-pressure
  input  wire logic                I_APPLY_HOLD,
  // Channel outputs and status
  output qdac_pkg::qdac_bank_t     O_OUT_BANK,
  output logic                     O_UPDATE,
  output logic                     O_CTRL_VALID
);

  typedef struct packed {
    logic                  scl_s1;
    logic                  scl_s2;
    logic                  scl_d;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  sda_d;
    logic [1:0]            sel_s1;
    logic [1:0]            sel_s2;
    logic [1:0]            sel_wait;
    logic [1:0]            sel_lat;
    logic                  sel_done;
    qdac_pkg::qdac_state_t state;
    logic [3:0]            bitcnt;
    logic [7:0]            shift;
    logic                  oe;
    logic                  sda_o;
    logic [7:0]            ctrl;
    logic                  ctrl_valid;
    logic [7:0]            upper;
    qdac_pkg::qdac_bank_t  temp_bank;
    qdac_pkg::qdac_bank_t  out_bank;
    logic                  upd;
  } qdac_st_t;

  qdac_st_t            s_r;
  qdac_st_t            s_nxt;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_c;
  logic                stop_c;
  logic                byte_done;
  logic                addr_ok;
  logic                push;
  qdac_pkg::qdac_upd_t push_data;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  qdac_pkg::qdac_upd_t fifo_out_data;
  logic                apply;
  qdac_pkg::qdac_mode_t mode;
  logic [1:0]          sel;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic qdac_pkg::qdac_chan_t load_chan(qdac_pkg::qdac_upd_t u, qdac_pkg::qdac_chan_t old);
    qdac_pkg::qdac_chan_t c;
    c = old;
    if (u.ctrl[qdac_pkg::CTRL_PD_BIT]) begin
      // Power-down request keeps the stored code
      c.pd = u.upper[qdac_pkg::UPPER_PD_MSB:qdac_pkg::UPPER_PD_LSB];
    end else begin
      c.pd   = qdac_pkg::PD_RST;
      c.code = {u.upper, u.lower[qdac_pkg::LOWER_CODE_MSB:qdac_pkg::LOWER_CODE_LSB]};
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  assign scl_rise  = s_r.scl_s2 && !s_r.scl_d;
  assign scl_fall  = !s_r.scl_s2 && s_r.scl_d;
  assign start_c   = s_r.scl_s2 && s_r.scl_d && s_r.sda_d && !s_r.sda_s2;
  assign stop_c    = s_r.scl_s2 && s_r.scl_d && !s_r.sda_d && s_r.sda_s2;
  assign byte_done = scl_fall && (s_r.bitcnt == qdac_pkg::BITS_PER_BYTE);
  // Local write, or broadcast write; master code, general call, ten-bit and reads fall through
  assign addr_ok   = ((s_r.shift[7:3] == qdac_pkg::ADDR_PREFIX) && (s_r.shift[2:1] == s_r.sel_lat)
                      && !s_r.shift[0]) || (s_r.shift == qdac_pkg::BCAST_ADDR);

  assign push_data = '{ctrl: s_r.ctrl, upper: s_r.upper, lower: s_r.shift};
  assign push      = (s_r.state == qdac_pkg::ST_ACK_LOWER) && scl_fall && !start_c && !stop_c;
  assign apply     = fifo_out_valid && !I_APPLY_HOLD;
  assign mode      = qdac_pkg::qdac_mode_t'(fifo_out_data.ctrl[qdac_pkg::CTRL_MODE_MSB:qdac_pkg::CTRL_MODE_LSB]);
  assign sel       = fifo_out_data.ctrl[qdac_pkg::CTRL_SEL_MSB:qdac_pkg::CTRL_SEL_LSB];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    qdac_pkg::qdac_chan_t w;
    w = '0;
    s_nxt = s_r;
    s_nxt.scl_s1 = I_SCL;
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.scl_d  = s_r.scl_s2;
    s_nxt.sda_s1 = I_SDA;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.sda_d  = s_r.sda_s2;
    s_nxt.sel_s1 = {I_DEV_SELECT_PIN_HI, I_DEV_SELECT_PIN_LO};
    s_nxt.sel_s2 = s_r.sel_s1;
    s_nxt.upd    = 1'b0;
    // Pins are caught once, after the synchroniser has filled
    if (!s_r.sel_done) begin
      s_nxt.sel_wait = 2'(s_r.sel_wait + 1'b1);
      if (s_r.sel_wait == qdac_pkg::SEL_CAPTURE_AT) begin
        s_nxt.sel_lat  = s_r.sel_s2;
        s_nxt.sel_done = 1'b1;
      end
    end

    if (stop_c) begin
      s_nxt.state = qdac_pkg::ST_IDLE;
      s_nxt.oe    = 1'b0;
    end else if (start_c) begin
      // Repeated start also lands here, so the high-speed sequence needs no extra state
      s_nxt.state  = qdac_pkg::ST_RX_ADDR;
      s_nxt.bitcnt = '0;
      s_nxt.oe     = 1'b0;
    end else begin
      unique case (s_r.state)
        qdac_pkg::ST_IDLE, qdac_pkg::ST_IGNORE: begin
          s_nxt.oe = 1'b0;
        end
        qdac_pkg::ST_RX_ADDR, qdac_pkg::ST_RX_CTRL,
        qdac_pkg::ST_RX_UPPER, qdac_pkg::ST_RX_LOWER: begin
          if (scl_rise) begin
            s_nxt.shift  = {s_r.shift[6:0], s_r.sda_s2};
            s_nxt.bitcnt = 4'(s_r.bitcnt + 1'b1);
          end
          if (byte_done) begin
            s_nxt.bitcnt = '0;
            s_nxt.state  = qdac_pkg::ST_IGNORE;
            unique case (s_r.state)
              qdac_pkg::ST_RX_ADDR: begin
                if (addr_ok) begin
                  s_nxt.state = qdac_pkg::ST_ACK_ADDR;
                  s_nxt.oe    = 1'b1;
                end
              end
              qdac_pkg::ST_RX_CTRL: begin
                if (s_r.shift[qdac_pkg::CTRL_RSV_MSB:qdac_pkg::CTRL_RSV_LSB] == 2'h0) begin
                  s_nxt.state      = qdac_pkg::ST_ACK_CTRL;
                  s_nxt.oe         = 1'b1;
                  s_nxt.ctrl       = s_r.shift;
                  s_nxt.ctrl_valid = 1'b1;
                end
              end
              qdac_pkg::ST_RX_UPPER: begin
                s_nxt.state = qdac_pkg::ST_ACK_UPPER;
                s_nxt.oe    = 1'b1;
                s_nxt.upper = s_r.shift;
              end
              default: begin
                // A full queue refuses the lower byte so the master sees the stall
                if (fifo_in_ready) begin
                  s_nxt.state = qdac_pkg::ST_ACK_LOWER;
                  s_nxt.oe    = 1'b1;
                end
              end
            endcase
          end
        end
        qdac_pkg::ST_ACK_ADDR, qdac_pkg::ST_ACK_CTRL,
        qdac_pkg::ST_ACK_UPPER, qdac_pkg::ST_ACK_LOWER: begin
          if (scl_fall) begin
            s_nxt.oe = 1'b0;
            unique case (s_r.state)
              qdac_pkg::ST_ACK_ADDR:  s_nxt.state = qdac_pkg::ST_RX_CTRL;
              qdac_pkg::ST_ACK_CTRL:  s_nxt.state = qdac_pkg::ST_RX_UPPER;
              qdac_pkg::ST_ACK_UPPER: s_nxt.state = qdac_pkg::ST_RX_LOWER;
              default:                s_nxt.state = qdac_pkg::ST_RX_UPPER;
            endcase
          end
        end
        default: begin
          s_nxt.state = qdac_pkg::ST_IDLE;
          s_nxt.oe    = 1'b0;
        end
      endcase
    end

    // Apply stage: channel index i is A..D for codes 00..11
    if (apply) begin
      s_nxt.upd = 1'b1;
      for (int i = 0; i < qdac_pkg::CHANS; i++) begin
        w = load_chan(fifo_out_data, s_r.temp_bank.chan[i]);
        unique case (mode)
          qdac_pkg::MODE_TEMP: begin
            if (sel == 2'(i)) begin
              s_nxt.temp_bank.chan[i] = w;
            end
          end
          qdac_pkg::MODE_DIRECT: begin
            if (sel == 2'(i)) begin
              s_nxt.temp_bank.chan[i] = w;
              s_nxt.out_bank.chan[i]  = w;
            end
          end
          qdac_pkg::MODE_SYNC: begin
            if (sel == 2'(i)) begin
              s_nxt.temp_bank.chan[i] = w;
              s_nxt.out_bank.chan[i]  = w;
            end else begin
              s_nxt.out_bank.chan[i] = s_r.temp_bank.chan[i];
            end
          end
          qdac_pkg::MODE_BCAST: begin
            s_nxt.temp_bank.chan[i] = w;
            s_nxt.out_bank.chan[i]  = w;
          end
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_NRST) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Update queue
  // ----------------------------------------------------------------
  qdac_fifo #(
    .W     (qdac_pkg::UPD_W),
    .DEPTH (qdac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLK),
    .i_nrst      (I_NRST),
    .i_in_valid  (push),
    .i_in_data   (push_data),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (!I_APPLY_HOLD)
  );

  assign O_SDA_O      = s_r.sda_o;
  assign O_SDA_OE     = s_r.oe;
  assign O_OUT_BANK   = s_r.out_bank;
  assign O_UPDATE     = s_r.upd;
  assign O_CTRL_VALID = s_r.ctrl_valid;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  property p_start_addr;
    start_c && !stop_c |=> (s_r.state == qdac_pkg::ST_RX_ADDR) && (s_r.bitcnt == 4'h0) && !O_SDA_OE;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start did not open address phase");

  property p_stop_release;
    stop_c |=> !O_SDA_OE && (s_r.state == qdac_pkg::ST_IDLE);
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("stop did not release the bus");

  property p_ack_hold;
    (O_SDA_OE && scl_rise && !start_c && !stop_c) |=> O_SDA_OE;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped during clock high");

  property p_addr_prefix;
    (s_r.state == qdac_pkg::ST_ACK_ADDR) |-> (s_r.shift[7:3] == qdac_pkg::ADDR_PREFIX)
      || (s_r.shift == qdac_pkg::BCAST_ADDR);
  endproperty
  a_addr_prefix: assert property (p_addr_prefix) else $error("address acknowledged without prefix");

  property p_sel_fixed;
    s_r.sel_done |=> $stable(s_r.sel_lat);
  endproperty
  a_sel_fixed: assert property (p_sel_fixed) else $error("select pins re-sampled");

  property p_bcast_ack;
    (s_r.state == qdac_pkg::ST_RX_ADDR) && byte_done && (s_r.shift == qdac_pkg::BCAST_ADDR)
      && !start_c && !stop_c |=> (s_r.state == qdac_pkg::ST_ACK_ADDR) && O_SDA_OE;
  endproperty
  a_bcast_ack: assert property (p_bcast_ack) else $error("broadcast address not acknowledged");

  property p_bcast_read;
    (s_r.state == qdac_pkg::ST_ACK_ADDR) && (s_r.shift[7:1] == qdac_pkg::BCAST_ADDR[7:1]) |-> !s_r.shift[0];
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("broadcast read acknowledged");

  property p_mcode_nack;
    (s_r.state == qdac_pkg::ST_RX_ADDR) && byte_done && (s_r.shift[7:3] == qdac_pkg::MCODE_PREFIX)
      |=> !O_SDA_OE;
  endproperty
  a_mcode_nack: assert property (p_mcode_nack) else $error("master code acknowledged");

  property p_push_at_fall;
    push |-> (s_r.state == qdac_pkg::ST_ACK_LOWER) && $past(s_r.scl_s2) && !s_r.scl_s2;
  endproperty
  a_push_at_fall: assert property (p_push_at_fall) else $error("update queued off the ack fall");

  property p_mode_temp;
    apply && (mode == qdac_pkg::MODE_TEMP) |=> $stable(s_r.out_bank) && O_UPDATE;
  endproperty
  a_mode_temp: assert property (p_mode_temp) else $error("temporary mode touched outputs");

  property p_mode_direct;
    apply && (mode == qdac_pkg::MODE_DIRECT) |=> s_r.out_bank.chan[$past(sel)] == s_r.temp_bank.chan[$past(sel)];
  endproperty
  a_mode_direct: assert property (p_mode_direct) else $error("direct mode output mismatch");

  property p_mode_bcast;
    apply && (mode == qdac_pkg::MODE_BCAST) |=> s_r.out_bank == s_r.temp_bank;
  endproperty
  a_mode_bcast: assert property (p_mode_bcast) else $error("broadcast mode left a channel behind");

  c_update: cover property (apply ##1 O_UPDATE);
  c_bcast:  cover property ((s_r.state == qdac_pkg::ST_ACK_ADDR) && (s_r.shift == qdac_pkg::BCAST_ADDR));
  c_pair:   cover property (push ##[1:300] push);
  c_stop:   cover property (stop_c);

endmodule

`default_nettype wire

/* design/qdac_pkg.sv */
// Package: constants, field layouts and carrier types of the quad converter update receiver
package qdac_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int CODE_W     = 12;
  localparam int CHANS      = 4;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Address byte
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_PREFIX  = 5'h13;
  localparam logic [7:0] BCAST_ADDR   = 8'h90;
  localparam logic [4:0] MCODE_PREFIX = 5'h01;

  // ----------------------------------------------------------------
  // Field positions of update_control_byte and data bytes
  // ----------------------------------------------------------------
  localparam int CTRL_RSV_MSB   = 7;
  localparam int CTRL_RSV_LSB   = 6;
  localparam int CTRL_MODE_MSB  = 5;
  localparam int CTRL_MODE_LSB  = 4;
  localparam int CTRL_SEL_MSB   = 2;
  localparam int CTRL_SEL_LSB   = 1;
  localparam int CTRL_PD_BIT    = 0;
  localparam int UPPER_PD_MSB   = 7;
  localparam int UPPER_PD_LSB   = 6;
  localparam int LOWER_CODE_MSB = 7;
  localparam int LOWER_CODE_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [11:0] CODE_RST        = 12'h000;
  localparam logic [1:0]  PD_RST          = 2'h0;
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [1:0]  SEL_CAPTURE_AT  = 2'h2;
  localparam int          PAIR_SCL_CYCLES = 18;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TEMP   = 2'b00,
    MODE_DIRECT = 2'b01,
    MODE_SYNC   = 2'b10,
    MODE_BCAST  = 2'b11
  } qdac_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_RX_ADDR   = 4'b0001,
    ST_ACK_ADDR  = 4'b0010,
    ST_RX_CTRL   = 4'b0011,
    ST_ACK_CTRL  = 4'b0100,
    ST_RX_UPPER  = 4'b0101,
    ST_ACK_UPPER = 4'b0110,
    ST_RX_LOWER  = 4'b0111,
    ST_ACK_LOWER = 4'b1000,
    ST_IGNORE    = 4'b1001
  } qdac_state_t;

  typedef struct packed {
    logic [1:0]        pd;
    logic [CODE_W-1:0] code;
  } qdac_chan_t;

  typedef struct packed {
    qdac_chan_t [CHANS-1:0] chan;
  } qdac_bank_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] upper;
    logic [7:0] lower;
  } qdac_upd_t;

  localparam int UPD_W = $bits(qdac_upd_t);

endpackage

/* design/qdac_fifo.sv */
// Parameterised FIFO with a registered output stage, valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module qdac_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // Fill side
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  // Drain side
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW:0]             count;
    logic [W-1:0]            out_data;
    logic                    out_valid;
  } qdac_fifo_st_t;

  qdac_fifo_st_t s_r;
  qdac_fifo_st_t s_nxt;
  logic          push;
  logic          pop;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    push  = i_in_valid && (s_r.count != FULL_CNT);
    // Output register refills whenever it is empty or being taken
    pop   = (s_r.count != '0) && (!s_r.out_valid || i_out_ready);
    if (i_out_ready) begin
      s_nxt.out_valid = 1'b0;
    end
    if (pop) begin
      s_nxt.out_data  = s_r.mem[s_r.rd_ptr];
      s_nxt.out_valid = 1'b1;
      s_nxt.rd_ptr    = AW'(s_r.rd_ptr + 1'b1);
    end
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = i_in_data;
      s_nxt.wr_ptr          = AW'(s_r.wr_ptr + 1'b1);
    end
    s_nxt.count = (AW+1)'(s_r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_in_ready  = (s_r.count != FULL_CNT);
  assign o_out_valid = s_r.out_valid;
  assign o_out_data  = s_r.out_data;

endmodule

`default_nettype wire

/* sim/qdac_bus_master.sv */
// Behavioural two-wire bus master for the update receiver bench
`timescale 1ns/1ps
`default_nettype none

module qdac_bus_master (
  // Clock
  input  wire logic i_clk,
  // Bus
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // Bus clock idles high between frames; n half-levels of 2 clocks
  task automatic q(input int n);
    repeat (2 * n) @(posedge i_clk);
    #1;
  endtask

  // Start or repeated start: data falls while clock high
  task automatic start();
    o_sda_low = 1'b0;
    q(1);
    o_scl = 1'b1;
    q(2);
    o_sda_low = 1'b1;
    q(2);
    o_scl = 1'b0;
    q(1);
  endtask

  task automatic stop();
    o_sda_low = 1'b1;
    q(1);
    o_scl = 1'b1;
    q(2);
    o_sda_low = 1'b0;
    q(2);
  endtask

  // Data settles mid-low, so it never moves while the clock is high
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_low = ~b[i];
      q(1);
      o_scl = 1'b1;
      q(2);
      o_scl = 1'b0;
      q(1);
    end
    o_sda_low = 1'b0;
    q(1);
    o_scl = 1'b1;
    q(1);
    ack = ~i_sda;
    q(1);
    o_scl = 1'b0;
    q(1);
  endtask
endmodule

`default_nettype wire

/* sim/test_qdac_i2c_update.sv */
// Self-checking bench for the two-wire quad converter update receiver
`timescale 1ns/1ps
`default_nettype none

module test_qdac_i2c_update;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic                 p_hi = 1'b0;
  logic                 p_lo = 1'b1;
  logic                 hold = 1'b0;
  logic                 scl;
  logic                 sda_low;
  logic                 sda_o;
  logic                 sda_oe;
  logic                 sda;
  logic                 upd;
  logic                 cval;
  qdac_pkg::qdac_bank_t bank;
  logic [13:0]          tmp [4];
  logic [13:0]          outm [4];
  int                   n_errors = 0;
  int                   n_compared = 0;
  int                   n_upd = 0;
  int                   cyc = 0;
  int                   t_upd = 0;
  int                   gap = 0;

  always #12.5 clk = ~clk;
  // Pull-up level whenever nobody pulls low
  assign sda = !(sda_low || (sda_oe && !sda_o));

  qdac_i2c_update dut (.I_CLK(clk), .I_NRST(nrst), .I_SCL(scl), .I_SDA(sda), .O_SDA_O(sda_o),
    .O_SDA_OE(sda_oe), .I_DEV_SELECT_PIN_HI(p_hi), .I_DEV_SELECT_PIN_LO(p_lo),
    .I_APPLY_HOLD(hold), .O_OUT_BANK(bank), .O_UPDATE(upd), .O_CTRL_VALID(cval));
  qdac_bus_master mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  // Gap in clocks between the last two update pulses
  always @(posedge clk) begin
    cyc++;
    if (upd === 1'b1) begin
      n_upd++;
      gap = cyc - t_upd;
      t_upd = cyc;
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [63:0] exp_bank();
    qdac_pkg::qdac_bank_t b;
    for (int i = 0; i < 4; i++) begin
      b.chan[i] = outm[i];
    end
    return 64'(b);
  endfunction

  task automatic model(input logic [7:0] c, input logic [7:0] u, input logic [7:0] l);
    for (int i = 0; i < 4; i++) begin
      if (c[5:4] == 2'b11 || i == c[2:1]) begin
        if (c[5:4] != 2'b00) begin
          outm[i] = c[0] ? {u[7:6], outm[i][11:0]} : {2'b00, u, l[7:4]};
        end
        tmp[i] = c[0] ? {u[7:6], tmp[i][11:0]} : {2'b00, u, l[7:4]};
      end else if (c[5:4] == 2'b10) begin
        outm[i] = tmp[i];
      end
    end
  endtask

  // Outputs must not move before the ack after the lower byte
  task automatic pair(input logic [7:0] u, input logic [7:0] l, output logic a);
    mst.send_byte(u, a);
    chk("upper ack", a, 1'b1);
    chk("early bank", 64'(bank), exp_bank());
    mst.send_byte(l, a);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    chk("reset bank", 64'(bank), 64'h0);
    chk("reset ctrl valid", cval, 1'b0);
    chk("reset oe", sda_oe, 1'b0);
    chk("drive level", sda_o, 1'b0);
  endtask

  // Pins move after capture; the address at the new pin levels must not match
  task automatic t_addr();
    logic [8:0] tb [10] = '{9'h19A, 9'h09B, 9'h09C, 9'h190, 9'h091, 9'h008, 9'h000, 9'h0F0, 9'h08A, 9'h0DA};
    logic       a;
    p_hi = 1'b1;
    p_lo = 1'b0;
    for (int i = 0; i < 10; i++) begin
      mst.start();
      mst.send_byte(tb[i][7:0], a);
      chk("address ack", a, tb[i][8]);
      mst.stop();
      chk("released", sda_oe, 1'b0);
    end
    mst.start();
    mst.send_byte(8'h0F, a);
    chk("master code ack", a, 1'b0);
    mst.start();
    mst.send_byte(8'h9A, a);
    chk("after rep start", a, 1'b1);
    mst.stop();
  endtask

  task automatic t_badctrl();
    logic a;
    mst.start();
    mst.send_byte(8'h9A, a);
    mst.send_byte(8'h4C, a);
    chk("bad ctrl ack", a, 1'b0);
    mst.send_byte(8'h12, a);
    chk("ignored byte", a, 1'b0);
    mst.stop();
    chk("ctrl invalid", cval, 1'b0);
  endtask

  task automatic t_modes();
    logic [31:0] tb [6] = '{32'h9A00_ABC0, 32'h9A12_1230, 32'h9A24_5670, 32'h9A0E_9A50, 32'h9036_FED0,
                            32'h9A13_C000};
    logic        a;
    int          u0;
    for (int i = 0; i < 6; i++) begin
      u0 = n_upd;
      mst.start();
      mst.send_byte(tb[i][31:24], a);
      chk("addr ack", a, 1'b1);
      mst.send_byte(tb[i][23:16], a);
      chk("ctrl ack", a, 1'b1);
      for (int k = 0; k < 2; k++) begin
        pair(tb[i][15:8] + 8'(k), tb[i][7:0], a);
        chk("lower ack", a, 1'b1);
        model(tb[i][23:16], tb[i][15:8] + 8'(k), tb[i][7:0]);
      end
      mst.stop();
      repeat (8) @(posedge clk);
      #1;
      chk("bank", 64'(bank), exp_bank());
      chk("updates", n_upd - u0, 2);
      chk("pair gap", gap, qdac_pkg::PAIR_SCL_CYCLES * 8);
      chk("ctrl valid", cval, 1'b1);
    end
  endtask

  // Stalled apply stage: the queue refuses a lower byte once full
  task automatic t_fifo();
    logic a;
    int   u0;
    int   n;
    u0 = n_upd;
    n = 0;
    hold = 1'b1;
    mst.start();
    mst.send_byte(8'h9A, a);
    mst.send_byte(8'h10, a);
    a = 1'b1;
    while (a === 1'b1 && n < 20) begin
      pair(8'(n), 8'h50, a);
      n += int'(a);
    end
    mst.stop();
    chk("queue depth", n >= 16 && n <= 17, 1'b1);
    hold = 1'b0;
    for (int t = 0; t < 300 && n_upd - u0 < n; t++) begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1;
    model(8'h10, 8'(n - 1), 8'h50);
    chk("drained", n_upd - u0, n);
    chk("bank drained", 64'(bank), exp_bank());
  endtask

  initial begin
    for (int i = 0; i < 4; i++) begin
      tmp[i] = 14'h0000;
      outm[i] = 14'h0000;
    end
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    t_reset();
    repeat (8) @(posedge clk);
    #1;
    t_addr();
    t_badctrl();
    t_modes();
    t_fifo();
    wrap_up();
  end

  // Whole run needs about 170 us of bus traffic
  initial begin
    #600_000;
    n_errors++;
    wrap_up();
  end
endmodule

`default_nettype wire
